// file: pkg/simon_pkg.sv
// package for the supply integrity reset monitor: offsets, fields, types
package simon_pkg;
    // =====================
    // register map
    localparam logic [11:0] SIMON_CSR_ADDR = 12'h000; // ctrl/status word
    // =====================
    // field positions of the ctrl/status register
    localparam int SIMON_BIT_SRC = 7;   // monitor_source_select
    localparam int SIMON_BIT_IE = 6;    // monitor_irq_enable
    localparam int SIMON_BIT_FLAG = 5;  // monitor_level_flag
    localparam int SIMON_BIT_SUP = 4;   // supply_reset_flag
    localparam int SIMON_BIT_WDG = 0;   // watchdog_reset_flag
    localparam logic [7:0] SIMON_CSR_RESET = 8'h00; // control bits reset
    // =====================
    // timing
    localparam int SIMON_CLK_HZ = 10000000;      // cpu clock rate
    localparam int SIMON_PULSE_NS = 20000;       // min reset pulse, ns
    localparam int SIMON_PULSE_CYC =
        (SIMON_PULSE_NS * (SIMON_CLK_HZ / 1000000) + 999) / 1000;
    localparam int SIMON_DLY_SHORT = 256;        // short reset delay
    localparam int SIMON_DLY_LONG = 4096;        // long reset delay
    localparam int SIMON_CNT_W = 13;             // delay counter width
    // =====================
    // types
    typedef enum logic [2:0] {
        SIMON_ST_RESET = 3'h1, // a reset source is active
        SIMON_ST_DELAY = 3'h2, // stabilisation delay
        SIMON_ST_RUN = 3'h4    // cpu runs
    } simon_state_t;
    typedef enum logic [1:0] {
        SIMON_CAUSE_PIN = 2'h0, // external pin
        SIMON_CAUSE_WDG = 2'h1, // watchdog
        SIMON_CAUSE_SUP = 2'h2  // supply
    } simon_cause_t;
    typedef struct packed {
        logic src;  // monitor_source_select
        logic ie;   // monitor_irq_enable
        logic flag; // monitor_level_flag
        logic sup;  // supply_reset_flag
        logic wdg;  // watchdog_reset_flag
    } simon_csr_t;
    typedef struct packed {
        simon_state_t st;            // reset sequence state
        simon_cause_t cause;         // latest reset cause
        logic [SIMON_CNT_W-1:0] cnt; // delay counter
        logic [SIMON_CNT_W-1:0] pcnt; // watchdog pulse counter
        simon_csr_t csr;             // register contents
        logic sync1;                 // synchroniser stage 1
        logic sync2;                 // synchroniser stage 2
        logic armed;                 // delay over, flag changes count
        logic pend;                  // pending monitor interrupt
        logic [31:0] prdata;         // read data
    } simon_state_s_t;
endpackage

// file: design/simon_top.sv
// supply integrity reset monitor: reset sequencing, flags, monitor irq
// How it works
// - low supply holds reset and pulls pin
// - watchdog underflow stretches pin low pulse
// - supply reset only if option enabled
// - monitor works only with supply reset enabled
// - bit 5 read-only live monitor level
// - bit 7 selects supply or sense pin
// - bit 6 enables irq on any flag change
// - pending irq cleared at service entry
// - irq needs enable and cleared cpu mask
// - no irq for crossing during reset delay
// - enabling while low gives immediate irq
// - irq wakes from wait, not halt
// - halt freezes the whole register
// - bit 4 set by supply reset, sw clears
// - supply flag survives pin and watchdog resets
// - bit 0 watchdog flag, cleared by supply reset
// - two flags encode last reset source
// - control bits read zero after reset
// - delay 256 or 4096 cycles after release
`timescale 1ns/1ps
module simon_top
    import simon_pkg::*;
#(
    parameter int DLY_LONG = SIMON_DLY_LONG, // long reset delay, cycles
    parameter int PULSE_CYC = SIMON_PULSE_CYC // watchdog pin pulse length
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // option settings, static
    input wire logic opt_supply_reset_en,
    input wire logic [1:0] opt_threshold_sel,
    input wire logic opt_long_delay,
    // analog comparators, asynchronous
    input wire logic low_voltage_reset_detector,
    input wire logic monitor_supply_cmp,
    input wire logic external_sense_pin,
    // other reset sources and cpu state
    input wire logic ext_reset_in,
    input wire logic watchdog_underflow,
    input wire logic condition_code_reg_mask,
    input wire logic irq_service_ack,
    input wire logic cpu_halt,
    input wire logic cpu_wait,
    // outputs
    output logic reset_pin_o,
    output logic reset_pin_oe_n,
    output logic cpu_reset,
    output logic [1:0] threshold_sel,
    output logic monitor_irq,
    output logic monitor_wake
);
    // =====================
    // state
    simon_state_s_t s_q; // all registered state
    simon_state_s_t s_d; // next state
    logic wr_acc; // write access phase
    logic rd_acc; // read setup phase
    logic hit; // address decodes to the register
    logic cmp_raw; // selected comparator, asynchronous
    logic [SIMON_CNT_W-1:0] dly_end; // selected delay length
    logic sup_low; // supply comparator active and enabled
    logic no_src; // no reset source asserted this cycle
    logic run_q; // sequence is in the run state
    logic wr_hit; // write access to the register
    logic sw_ok; // cycle in which software access can land

    assign hit = (paddr == SIMON_CSR_ADDR);
    assign wr_acc = psel && penable && pwrite;
    // read data is loaded in the setup phase so it stands at the access edge
    assign rd_acc = psel && !penable && !pwrite;
    assign sup_low = opt_supply_reset_en && low_voltage_reset_detector;
    // helpers shared by the checks below
    assign no_src = !sup_low && !watchdog_underflow && !ext_reset_in;
    assign run_q = (s_q.st == SIMON_ST_RUN);
    assign wr_hit = wr_acc && hit;
    assign sw_ok = clk_en && run_q && !cpu_halt && no_src;
    // source mux in front of the synchroniser
    assign cmp_raw = s_q.csr.src ? external_sense_pin : monitor_supply_cmp;
    assign dly_end = opt_long_delay ? SIMON_CNT_W'(DLY_LONG - 1)
                                    : SIMON_CNT_W'(SIMON_DLY_SHORT - 1);

    // =====================
    // next state logic
    always_comb begin
        s_d = s_q;
        // comparator synchroniser, stage 1 only feeds stage 2
        s_d.sync1 = cmp_raw;
        s_d.sync2 = s_q.sync1;
        // watchdog pulse stretcher
        if (watchdog_underflow) begin
            s_d.pcnt = SIMON_CNT_W'(PULSE_CYC);
        end else if (s_q.pcnt != '0) begin
            s_d.pcnt = s_q.pcnt - SIMON_CNT_W'(1);
        end
        // reset sequence
        unique case (s_q.st)
            SIMON_ST_RESET: begin
                s_d.cnt = '0;
                if (!sup_low && !ext_reset_in && s_d.pcnt == '0) begin
                    s_d.st = SIMON_ST_DELAY;
                end
            end
            SIMON_ST_DELAY: begin
                s_d.cnt = s_q.cnt + SIMON_CNT_W'(1);
                if (s_q.cnt == dly_end) begin
                    s_d.st = SIMON_ST_RUN;
                    s_d.armed = 1'b1;
                end
            end
            SIMON_ST_RUN: begin
                s_d.cnt = '0;
            end
            default: begin
                s_d.st = SIMON_ST_RESET;
            end
        endcase
        // any reset source restarts the sequence
        if (sup_low) begin
            s_d.st = SIMON_ST_RESET;
            s_d.cause = SIMON_CAUSE_SUP;
        end else if (watchdog_underflow) begin
            s_d.st = SIMON_ST_RESET;
            s_d.cause = SIMON_CAUSE_WDG;
        end else if (ext_reset_in) begin
            s_d.st = SIMON_ST_RESET;
            s_d.cause = SIMON_CAUSE_PIN;
        end
        if (s_d.st == SIMON_ST_RESET) begin
            // control bits cleared, flag tracking halted
            s_d.csr.src = 1'b0;
            s_d.csr.ie = 1'b0;
            s_d.pend = 1'b0;
            s_d.armed = 1'b0;
            unique case (s_d.cause)
                SIMON_CAUSE_SUP: begin
                    s_d.csr.sup = 1'b1;
                    s_d.csr.wdg = 1'b0;
                end
                SIMON_CAUSE_WDG: begin
                    s_d.csr.wdg = 1'b1;
                end
                SIMON_CAUSE_PIN: begin
                    s_d.csr.wdg = 1'b0;
                end
                default: begin
                    s_d.cause = SIMON_CAUSE_PIN;
                end
            endcase
        end
        // running: monitor flag, irq and software access
        if (s_q.st == SIMON_ST_RUN && s_d.st == SIMON_ST_RUN) begin
            if (opt_supply_reset_en) begin
                s_d.csr.flag = s_q.sync2;
            end else begin
                s_d.csr.flag = 1'b0;
            end
            if (irq_service_ack) begin
                s_d.pend = 1'b0;
            end
            if (wr_acc && hit) begin
                s_d.csr.src = pwdata[SIMON_BIT_SRC];
                s_d.csr.ie = pwdata[SIMON_BIT_IE];
                // flags: software can only clear them
                if (!pwdata[SIMON_BIT_SUP]) begin
                    s_d.csr.sup = 1'b0;
                end
                if (!pwdata[SIMON_BIT_WDG]) begin
                    s_d.csr.wdg = 1'b0;
                end
                // enabling while under-voltage raises one at once
                if (pwdata[SIMON_BIT_IE] && !s_q.csr.ie && s_q.csr.flag
                    && opt_supply_reset_en) begin
                    s_d.pend = 1'b1;
                end
            end
            // a change of the flag wins over the service clear
            if (s_q.armed && s_d.csr.ie && opt_supply_reset_en
                && s_d.csr.flag != s_q.csr.flag) begin
                s_d.pend = 1'b1;
            end
        end
        // read data latched during the setup phase, stands in access
        if (rd_acc) begin
            s_d.prdata = '0;
            if (hit) begin
                s_d.prdata[SIMON_BIT_SRC] = s_q.csr.src;
                s_d.prdata[SIMON_BIT_IE] = s_q.csr.ie;
                s_d.prdata[SIMON_BIT_FLAG] = s_q.csr.flag;
                s_d.prdata[SIMON_BIT_SUP] = s_q.csr.sup;
                s_d.prdata[SIMON_BIT_WDG] = s_q.csr.wdg;
            end
        end
        // halt freezes the register except reset sources
        if (cpu_halt && s_d.st == SIMON_ST_RUN) begin
            s_d.csr = s_q.csr;
            s_d.pend = s_q.pend;
        end
    end

    // =====================
    // state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{st: SIMON_ST_RESET, cause: SIMON_CAUSE_SUP,
                     cnt: '0, pcnt: '0,
                     // system reset counts as a supply reset
                     csr: '{src: 1'b0, ie: 1'b0, flag: 1'b0,
                            sup: 1'b1, wdg: 1'b0},
                     sync1: 1'b0, sync2: 1'b0, armed: 1'b0,
                     pend: 1'b0, prdata: '0};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // =====================
    // outputs
    assign prdata = s_q.prdata;
    assign pready = 1'b1; // answer in the access cycle, data already set
    assign pslverr = psel && penable && !hit;
    assign reset_pin_o = 1'b0;
    // pin pulled low during reset and delay phases
    assign reset_pin_oe_n = (s_q.st == SIMON_ST_RUN) && (s_q.pcnt == '0);
    assign cpu_reset = (s_q.st != SIMON_ST_RUN);
    assign threshold_sel = opt_threshold_sel;
    assign monitor_irq = s_q.pend && !condition_code_reg_mask;
    // wait wakeup only; halt stays asleep
    assign monitor_wake = s_q.pend && cpu_wait && !cpu_halt;

    // =====================
    // assertions
    a_pin_low_reset: assert property (@(posedge clock) disable iff (!nrst)
        cpu_reset |-> !reset_pin_oe_n)
        else $error("reset pin released during reset");
    a_irq_mask_gate: assert property (@(posedge clock) disable iff (!nrst)
        monitor_irq |-> s_q.pend && !condition_code_reg_mask)
        else $error("irq without pending or with mask");
    a_halt_freeze: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && cpu_halt && !cpu_reset && !sup_low && !ext_reset_in
        && !watchdog_underflow |=> $stable(s_q.csr))
        else $error("register changed in halt");
    a_wdg_pulse: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && watchdog_underflow |=> reset_pin_oe_n == 1'b0)
        else $error("no pin pulse after underflow");
    a_sup_flag_set: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && sup_low |=> s_q.csr.sup && !s_q.csr.wdg)
        else $error("supply flags wrong after supply reset");
    a_ctrl_clear: assert property (@(posedge clock) disable iff (!nrst)
        cpu_reset |-> !s_q.csr.ie && !s_q.csr.src && !s_q.pend)
        else $error("control bits set during reset");
    a_ack_clears: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && irq_service_ack && !cpu_halt && !cpu_reset
        && !wr_acc && $stable(s_q.sync2) && s_q.csr.flag == s_q.sync2
        |=> !s_q.pend)
        else $error("pending not cleared by service");
    a_no_irq_delay: assert property (@(posedge clock) disable iff (!nrst)
        s_q.st == SIMON_ST_DELAY |-> !s_q.pend)
        else $error("irq pending during delay");
    a_pin_flag_keep: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && ext_reset_in && !sup_low && !watchdog_underflow
        |=> s_q.csr.sup == $past(s_q.csr.sup))
        else $error("supply flag lost on pin reset");

    // =====================
    // further checks on sequencing
    // supply low forces the cpu into reset
    a_reset_on_sup: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && sup_low |=> cpu_reset)
        else $error("no reset on low supply");

    // cpu stays in reset through the delay phase
    a_delay_cpu_reset: assert property (@(posedge clock) disable iff (!nrst)
        !run_q |-> cpu_reset)
        else $error("cpu released before delay end");

    // a running pulse counter keeps the pin low
    a_pulse_pin_low: assert property (@(posedge clock) disable iff (!nrst)
        s_q.pcnt != '0 |-> !reset_pin_oe_n)
        else $error("pin released during watchdog pulse");

    // threshold option reaches the comparator untouched
    a_threshold_pass: assert property (@(posedge clock) disable iff (!nrst)
        threshold_sel == opt_threshold_sel)
        else $error("threshold select differs from option");

    // =====================
    // checks on the monitor path
    // stage two only ever copies stage one
    a_sync_chain: assert property (@(posedge clock) disable iff (!nrst)
        clk_en |=> s_q.sync2 == $past(s_q.sync1))
        else $error("synchroniser stage skipped");

    // stage one follows the selected comparator
    a_src_select: assert property (@(posedge clock) disable iff (!nrst)
        clk_en |=> s_q.sync1 == $past(cmp_raw))
        else $error("wrong comparator selected");

    // flag follows the synchronised level while running
    a_flag_tracks: assert property (@(posedge clock) disable iff (!nrst)
        sw_ok && opt_supply_reset_en
        |=> s_q.csr.flag == $past(s_q.sync2))
        else $error("flag does not track comparator");

    // without the option the flag stays low
    a_no_opt_flag: assert property (@(posedge clock) disable iff (!nrst)
        sw_ok && !opt_supply_reset_en |=> !s_q.csr.flag)
        else $error("flag set without option");

    // without the option no interrupt becomes pending
    a_no_opt_irq: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && !opt_supply_reset_en && !s_q.pend |=> !s_q.pend)
        else $error("irq pending without option");

    // irq only after the delay phase is over
    a_armed_run: assert property (@(posedge clock) disable iff (!nrst)
        s_q.armed |-> run_q)
        else $error("armed outside run state");

    // every flag change with enable set raises a request
    a_change_sets: assert property (@(posedge clock) disable iff (!nrst)
        sw_ok && opt_supply_reset_en && s_q.armed && s_q.csr.ie
        && !wr_hit && s_q.sync2 != s_q.csr.flag |=> s_q.pend)
        else $error("flag change without irq");

    // enabling while under-voltage requests at once
    a_enable_low_irq: assert property (@(posedge clock) disable iff (!nrst)
        sw_ok && wr_hit && pwdata[SIMON_BIT_IE] && !s_q.csr.ie
        && s_q.csr.flag && opt_supply_reset_en |=> s_q.pend)
        else $error("no irq when enabled under-voltage");

    // wake only with pending request in wait
    a_wake_gate: assert property (@(posedge clock) disable iff (!nrst)
        monitor_wake |-> s_q.pend && cpu_wait)
        else $error("wake without pending in wait");

    // halt is never left by this request
    a_halt_no_wake: assert property (@(posedge clock) disable iff (!nrst)
        cpu_halt |-> !monitor_wake)
        else $error("wake during halt");

    // =====================
    // checks on software access and flags
    // source select takes the written bit
    a_src_write: assert property (@(posedge clock) disable iff (!nrst)
        sw_ok && wr_hit
        |=> s_q.csr.src == $past(pwdata[SIMON_BIT_SRC]))
        else $error("source select not written");

    // irq enable takes the written bit
    a_ie_write: assert property (@(posedge clock) disable iff (!nrst)
        sw_ok && wr_hit
        |=> s_q.csr.ie == $past(pwdata[SIMON_BIT_IE]))
        else $error("irq enable not written");

    // writing zero clears the supply flag
    a_sw_clear_sup: assert property (@(posedge clock) disable iff (!nrst)
        sw_ok && wr_hit && !pwdata[SIMON_BIT_SUP] |=> !s_q.csr.sup)
        else $error("supply flag not cleared");

    // watchdog reset sets its flag
    a_wdg_flag_set: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && watchdog_underflow && !sup_low |=> s_q.csr.wdg)
        else $error("watchdog flag not set");

    // pin reset leaves the watchdog flag clear
    a_pin_cause_wdg: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && ext_reset_in && !sup_low && !watchdog_underflow
        |=> !s_q.csr.wdg)
        else $error("watchdog flag set on pin reset");

    // read data shows the live flag from setup
    a_rd_setup: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && psel && !penable && !pwrite && hit
        |=> prdata[SIMON_BIT_FLAG] == $past(s_q.csr.flag))
        else $error("read data misses the flag");
endmodule

// file: dv/simon_cpu_model.sv
// partner model: cpu entering the monitor interrupt routine
`timescale 1ns/1ps
module simon_cpu_model #(
    parameter int ACK_DLY = 3 // routine entered ACK_DLY+1 cycles after request
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic monitor_irq,
    output logic irq_service_ack
);
    int cnt; // latency before the vector is taken
    // ==========
    // service entry: one pulse per taken request
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            irq_service_ack <= 1'h0;
        end else begin
            irq_service_ack <= 1'h0;
            // request seen, not yet entered
            if (monitor_irq === 1'h1 && !irq_service_ack) begin
                cnt <= cnt + 1;
                if (cnt == ACK_DLY) begin
                    irq_service_ack <= 1'h1;
                    cnt <= 0;
                end
            end
        end
    end
endmodule

// file: dv/simon_top_tb_top.sv
// self-checking bench: reset sequencing, flags, monitor irq
`timescale 1ns/1ps
module simon_top_tb_top;
    import simon_pkg::*;
    // ==========
    // signals
    localparam int DLY = 16; // shortened long delay
    localparam int PW = 8; // shortened pin pulse
    localparam logic [11:0] A = SIMON_CSR_ADDR;
    logic clock = 1'h0;
    logic nrst = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic clk_en = 1'h1, opt_supply_reset_en = 1'h1;
    logic opt_long_delay = 1'h1, ext_reset_in = 1'h0;
    logic [1:0] opt_threshold_sel = 2'h2;
    logic low_voltage_reset_detector = 1'h0;
    logic monitor_supply_cmp = 1'h0, external_sense_pin = 1'h0;
    logic watchdog_underflow = 1'h0, condition_code_reg_mask = 1'h0;
    logic cpu_halt = 1'h0, cpu_wait = 1'h0, irq_service_ack;
    logic [31:0] prdata;
    logic pready, pslverr, reset_pin_o, reset_pin_oe_n;
    logic cpu_reset, monitor_irq, monitor_wake;
    logic [1:0] threshold_sel;
    logic [31:0] rd; // last read data
    logic err; // last slave error
    int fail_count = 0, tests_run = 0, n;
    // ==========
    // design and partner
    simon_top #(.DLY_LONG(DLY), .PULSE_CYC(PW)) u_dut (.clock, .nrst,
        .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .opt_supply_reset_en, .opt_threshold_sel,
        .opt_long_delay, .low_voltage_reset_detector,
        .monitor_supply_cmp, .external_sense_pin, .ext_reset_in,
        .watchdog_underflow, .condition_code_reg_mask,
        .irq_service_ack, .cpu_halt, .cpu_wait, .reset_pin_o,
        .reset_pin_oe_n, .cpu_reset, .threshold_sel, .monitor_irq,
        .monitor_wake);
    simon_cpu_model u_cpu (.clock, .nrst, .monitor_irq,
        .irq_service_ack);
    // 100 ns clock
    always #50 clock = ~clock;
    // ==========
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // a wait that ran out ends the run
    task automatic bound();
        if (n >= 400) begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask
    // one apb transfer: setup, access until pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 400);
        bound();
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        rd = prdata;
    endtask
    task automatic rel();
        n = 0;
        while (cpu_reset !== 1'h0 && n < 400) begin
            @(negedge clock);
            n++;
        end
        bound();
    endtask
    task automatic wirq(input logic v);
        n = 0;
        while (monitor_irq !== v && n < 400) begin
            @(negedge clock);
            n++;
        end
        bound();
    endtask
    // ==========
    // scenarios
    task automatic s_boot();
        rel();
        check(32'(n >= DLY), 32'h1);
        apb(1'h0, A, 32'h0);
        check(rd, 32'h10);
        check(32'(threshold_sel), 32'(opt_threshold_sel));
        apb(1'h0, 12'h004, 32'h0);
        check(32'(err), 32'h1);
    endtask
    task automatic s_wdg();
        tick(1);
        watchdog_underflow <= 1'h1;
        tick(1);
        watchdog_underflow <= 1'h0;
        @(negedge clock);
        n = 0;
        while (reset_pin_oe_n === 1'h0 && n < 400) begin
            @(negedge clock);
            n++;
        end
        check(32'(n >= PW), 32'h1);
        rel();
        apb(1'h0, A, 32'h0);
        check(rd, 32'h11);
    endtask
    task automatic s_lvd();
        tick(1);
        low_voltage_reset_detector <= 1'h1;
        repeat (4) @(negedge clock);
        check({cpu_reset, reset_pin_oe_n}, 32'h2);
        tick(1);
        low_voltage_reset_detector <= 1'h0;
        rel();
        apb(1'h0, A, 32'h0);
        check(rd, 32'h10);
    endtask
    task automatic s_regs();
        apb(1'h1, A, 32'hC0);
        apb(1'h0, A, 32'h0);
        check(rd, 32'hC0);
        apb(1'h1, A, 32'h80);
    endtask
    task automatic s_irq();
        tick(1);
        external_sense_pin <= 1'h1;
        repeat (6) @(negedge clock);
        check(32'(monitor_irq), 32'h0);
        apb(1'h0, A, 32'h0);
        check(rd, 32'hA0);
        tick(1);
        condition_code_reg_mask <= 1'h1;
        cpu_wait <= 1'h1;
        apb(1'h1, A, 32'hC0);
        @(negedge clock);
        check({monitor_irq, monitor_wake}, 32'h1);
        tick(1);
        condition_code_reg_mask <= 1'h0;
        cpu_wait <= 1'h0;
        wirq(1'h1);
        wirq(1'h0);
        tick(1);
        monitor_supply_cmp <= 1'h1;
        repeat (6) @(negedge clock);
        check(32'(monitor_irq), 32'h0);
        tick(1);
        external_sense_pin <= 1'h0;
        wirq(1'h1);
        wirq(1'h0);
    endtask
    task automatic s_halt();
        tick(1);
        cpu_halt <= 1'h1;
        external_sense_pin <= 1'h1;
        apb(1'h1, A, 32'h0);
        apb(1'h0, A, 32'h0);
        check(rd, 32'hC0);
        tick(1);
        external_sense_pin <= 1'h0;
        tick(4);
        cpu_halt <= 1'h0;
    endtask
    // ==========
    // main sequence
    initial begin
        tick(3);
        nrst <= 1'h1;
        s_boot();
        s_wdg();
        s_lvd();
        s_regs();
        s_irq();
        s_halt();
        finish_test();
    end
endmodule
